// ===== vdm_pkg.sv
// Package of the voltage distortion monitor: register map, field layout,
// reset values, condition and behaviour codes, and the shared record types.
// Assumes a 32-bit AHB-Lite register bus and a 5 ms processing tick.
package vdm_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] VDM_OFS_CTRL      = 8'h00;
   localparam logic [7:0] VDM_OFS_PICKUP    = 8'h04;
   localparam logic [7:0] VDM_OFS_DELAY     = 8'h08;
   localparam logic [7:0] VDM_OFS_EVTSEL    = 8'h0C;
   localparam logic [7:0] VDM_OFS_STATUS    = 8'h10;
   localparam logic [7:0] VDM_OFS_CNTCLR    = 8'h14;
   localparam logic [7:0] VDM_OFS_CNT_START = 8'h18;
   localparam logic [7:0] VDM_OFS_CNT_ALARM = 8'h1C;
   localparam logic [7:0] VDM_OFS_CNT_BLK   = 8'h20;
   localparam logic [7:0] VDM_OFS_LOGSEL    = 8'h24;
   localparam logic [7:0] VDM_OFS_LOG_TLO   = 8'h28;
   localparam logic [7:0] VDM_OFS_LOG_THI   = 8'h2C;
   localparam logic [7:0] VDM_OFS_LOG_THDA  = 8'h30;
   localparam logic [7:0] VDM_OFS_LOG_THDB  = 8'h34;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_ALLOW_BIT = 1;
   localparam int CTRL_MODE_LSB  = 2;
   localparam int CTRL_PWR_BIT   = 5;
   localparam int CTRL_GRP_LSB   = 8;
   localparam int THD_W          = 14;     // 0.01 % units, up to 100.00 %
   localparam int DLY_W          = 19;     // 5 ms steps, up to 1800 s
   localparam int CNT_W          = 16;
   localparam int TIME_W         = 48;     // Millisecond time stamp
   localparam int LOG_DEPTH      = 12;
   localparam logic [13:0] PICKUP_RST  = 14'h03E8;   // 10.00 %
   localparam logic [18:0] DELAY_RST   = 19'h0_07D0; // 2000 x 5 ms = 10.000 s
   localparam logic [5:0]  EVTSEL_RST  = 6'h3F;      // ON and OFF stored
   localparam int TICK_MS        = 5;      // Processing cycle and delay step
   localparam int RESET_RATIO    = 97;     // Release percentage of pick-up
   localparam int PERCENT        = 100;

   // ----------------------------------------------------------------------
   // Condition, behaviour and event codes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      COND_NORMAL  = 2'b00,
      COND_START   = 2'b01,
      COND_ALARM   = 2'b10,
      COND_BLOCKED = 2'b11
   } vdm_cond_e;

   typedef enum logic [2:0] {
      BEH_ON       = 3'b000,
      BEH_BLOCKED  = 3'b001,
      BEH_TEST     = 3'b010,
      BEH_TEST_BLK = 3'b011,
      BEH_OFF      = 3'b100
   } vdm_beh_e;

   localparam int EV_START = 0;
   localparam int EV_ALARM = 1;
   localparam int EV_BLK   = 2;

   // One log record
   typedef struct packed {
      logic [TIME_W-1:0]       stamp;
      logic [1:0]              evt_id;   // 1 start, 2 alarm, 3 blocked
      logic [2:0][THD_W-1:0]   thd;
      logic [2:0]              group;
   } vdm_log_s;

endpackage : vdm_pkg

// ===== vdm_monitor.sv
// Voltage distortion monitor with event stamping, counters and ON log.
// Assumes THD values, tick and blocking come from logic on sys_clk_i,
// and a single AHB-Lite master on the register bus.
`timescale 1ns/1ns

// Contract
// - Disabled alarm path gives no start or alarm
// - Compare every phase THD each processing cycle
// - Release only below 97 % of threshold
// - One threshold, any phase picks up
// - Threshold in 0.01 %, default 10.00 %
// - Settings change while running, no halt
// - Blocking sampled once at cycle start
// - Unblocked pick-up raises start, runs timer
// - Blocked pick-up raises blocked, nothing else
// - Blocking clears active start like release
// - Definite delay, 5 ms step, 10 s default
// - ON/OFF events, per-event storage selection
// - Each event carries its time stamp
// - Clearable counters for start, alarm, blocked
// - Circular log of twelve latest ON records
// - Log holds time, event, THDs, group
// - Condition code normal, start, alarm, blocked
// - Behaviour reported only when mode setting allowed
// - Start, alarm, blocked as binary outputs
// - THD taken from 32-component FFT per channel
// - Shared amplitude or power ratio select
module vdm_monitor
   import vdm_pkg::*;
(
   // Clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // AHB-Lite slave
   input  wire logic                hsel_i,
   input  wire logic [31:0]         haddr_i,
   input  wire logic [1:0]          htrans_i,
   input  wire logic                hwrite_i,
   input  wire logic [2:0]          hsize_i,
   input  wire logic [31:0]         hwdata_i,
   input  wire logic                hready_i,
   output logic      [31:0]         hrdata_o,
   output logic                     hreadyout_o,
   output logic                     hresp_o,
   // Measurement front end and blocking matrix
   input  wire logic                cycle_tick_i,
   input  wire logic [THD_W-1:0]    thd_l1_i,
   input  wire logic [THD_W-1:0]    thd_l2_i,
   input  wire logic [THD_W-1:0]    thd_l3_i,
   input  wire logic                block_i,
   input  wire logic [TIME_W-1:0]   time_ms_i,
   output logic                     meas_power_o,
   // Binary outputs and status
   output logic                     start_o,
   output logic                     alarm_o,
   output logic                     blocked_o,
   output logic      [1:0]          cond_o,
   output logic      [2:0]          behav_o,
   output logic                     behav_valid_o,
   // Event stream
   output logic      [2:0]          evt_valid_o,
   output logic      [2:0]          evt_on_o,
   output logic      [TIME_W-1:0]   evt_time_o
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0]                  hrdata;
      logic                         wr_pend;
      logic [7:0]                   wr_addr;
      logic                         enable;
      logic                         ln_allow;
      logic [2:0]                   ln_mode;
      logic                         meas_power;
      logic [2:0]                   group;
      logic [THD_W-1:0]             pickup;
      logic [DLY_W-1:0]             delay;
      logic [5:0]                   evt_sel;
      logic [3:0]                   log_sel;
      logic                         blk;
      logic                         picked;
      logic                         start;
      logic                         alarm;
      logic                         blocked;
      logic [DLY_W-1:0]             tmr;
      logic [1:0]                   cond;
      logic [2:0]                   behav;
      logic [2:0]                   evt_valid;
      logic [2:0]                   evt_on;
      logic [TIME_W-1:0]            evt_time;
      logic [2:0][CNT_W-1:0]        cnt;
      logic [3:0]                   wp;
      logic [3:0]                   fill;
      vdm_log_s [LOG_DEPTH-1:0]     log;
   } vdm_state_s;

   vdm_state_s r;
   vdm_state_s next_r;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Wrap a sum of two log indices into the ring
   function automatic logic [3:0] vdm_wrap(input logic [4:0] v);
      logic [4:0] w;
      w = (v >= 5'(LOG_DEPTH)) ? v - 5'(LOG_DEPTH) : v;
      return w[3:0];
   endfunction : vdm_wrap

   // Pick-up level test with hysteresis for one phase
   function automatic logic vdm_over(input logic [THD_W-1:0] thd,
                                      input logic [THD_W-1:0] thr,
                                      input logic             held);
      logic [20:0] lhs;
      logic [20:0] rhs;
      lhs = 21'(thd) * 21'(PERCENT);
      rhs = 21'(thr) * 21'(RESET_RATIO);
      return held ? (lhs >= rhs) : (thd > thr);
   endfunction : vdm_over

   logic [2:0][THD_W-1:0] thd_in;
   assign thd_in = {thd_l3_i, thd_l2_i, thd_l1_i};

   // Combinational views used by logic and assertions
   logic       active;
   logic       force_blk;
   logic       blk_now;
   logic       pick_now;
   logic [2:0] beh_now;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic [2:0]         prev;
      logic [2:0]         now;
      logic [2:0]         rise;
      logic [2:0]         fall;
      logic [1:0]         n_on;
      logic [1:0]         id_a;
      logic [1:0]         id_b;
      logic [3:0]         clr;
      logic [3:0]         rd_idx;
      vdm_log_s           ent;
      logic               addr_ok;
      next_r   = r;
      prev     = {r.blocked, r.alarm, r.start};
      clr      = 4'h0;
      addr_ok  = hsel_i && htrans_i[1] && hready_i;
      // Local scratch values start from zero on every pass
      now      = '0;
      rise     = '0;
      fall     = '0;
      n_on     = '0;
      id_a     = '0;
      id_b     = '0;
      rd_idx   = '0;
      ent      = '0;

      // Behaviour from mode setting
      beh_now = r.ln_allow ? r.ln_mode : BEH_ON;
      case (beh_now)
         BEH_ON:       begin active = 1'b1; force_blk = 1'b0; end
         BEH_TEST:     begin active = 1'b1; force_blk = 1'b0; end
         BEH_BLOCKED:  begin active = 1'b1; force_blk = 1'b1; end
         BEH_TEST_BLK: begin active = 1'b1; force_blk = 1'b1; end
         default:      begin active = 1'b0; force_blk = 1'b0; end
      endcase
      active = active && r.enable;

      // Blocking sampled at the tick, held through the cycle
      blk_now = cycle_tick_i ? (block_i || force_blk) : r.blk;
      pick_now = active && (vdm_over(thd_in[0], r.pickup, r.picked) ||
                            vdm_over(thd_in[1], r.pickup, r.picked) ||
                            vdm_over(thd_in[2], r.pickup, r.picked));

      // Evaluation once per processing cycle
      next_r.evt_valid = 3'b000;
      next_r.evt_on    = 3'b000;
      if (cycle_tick_i) begin
         next_r.blk     = blk_now;
         next_r.picked  = pick_now;
         next_r.start   = pick_now && !blk_now;
         next_r.blocked = pick_now && blk_now;
         if (next_r.start) begin
            next_r.tmr   = r.start ? ((r.tmr == '1) ? r.tmr : r.tmr + 1'b1) : '0;
            next_r.alarm = (next_r.tmr >= r.delay);
         end else begin
            next_r.tmr   = '0;
            next_r.alarm = 1'b0;
         end
      end

      // Condition code
      if (next_r.blocked) begin
         next_r.cond = COND_BLOCKED;
      end else if (next_r.alarm) begin
         next_r.cond = COND_ALARM;
      end else if (next_r.start) begin
         next_r.cond = COND_START;
      end else begin
         next_r.cond = COND_NORMAL;
      end
      next_r.behav = beh_now;

      // Edge events with selection and stamp
      now  = {next_r.blocked, next_r.alarm, next_r.start};
      rise = now & ~prev;
      fall = prev & ~now;
      for (int k = 0; k < 3; k++) begin
         next_r.evt_valid[k] = (rise[k] && r.evt_sel[2*k]) ||
                               (fall[k] && r.evt_sel[2*k+1]);
         next_r.evt_on[k]    = rise[k];
      end
      if (|(rise | fall)) begin
         next_r.evt_time = time_ms_i;
      end

      // Bus writes in the data phase
      if (r.wr_pend) begin
         case (r.wr_addr)
            VDM_OFS_CTRL: begin
               next_r.enable     = hwdata_i[CTRL_EN_BIT];
               next_r.ln_allow   = hwdata_i[CTRL_ALLOW_BIT];
               next_r.ln_mode    = hwdata_i[CTRL_MODE_LSB +: 3];
               next_r.meas_power = hwdata_i[CTRL_PWR_BIT];
               next_r.group      = hwdata_i[CTRL_GRP_LSB +: 3];
            end
            VDM_OFS_PICKUP: next_r.pickup  = hwdata_i[THD_W-1:0];
            VDM_OFS_DELAY:  next_r.delay   = hwdata_i[DLY_W-1:0];
            VDM_OFS_EVTSEL: next_r.evt_sel = hwdata_i[5:0];
            VDM_OFS_CNTCLR: clr[2:0]       = hwdata_i[2:0];
            VDM_OFS_LOGSEL: next_r.log_sel = (hwdata_i[3:0] > 4'(LOG_DEPTH-1)) ?
                                             4'(LOG_DEPTH-1) : hwdata_i[3:0];
            default: ;
         endcase
      end

      // Counters, a clear and an edge in the same cycle leave a count of one
      for (int k = 0; k < 3; k++) begin
         if (rise[k]) begin
            next_r.cnt[k] = clr[k] ? CNT_W'(1) : r.cnt[k] + 1'b1;
         end else if (clr[k]) begin
            next_r.cnt[k] = '0;
         end
      end

      // Log of ON records, start and alarm may land together
      n_on = 2'(rise[0]) + 2'(rise[1]) + 2'(rise[2]);
      id_a = rise[0] ? 2'd1 : (rise[1] ? 2'd2 : 2'd3);
      id_b = 2'd2;
      ent.stamp = time_ms_i;
      ent.thd   = thd_in;
      ent.group = r.group;
      ent.evt_id = id_a;
      if (n_on != 2'd0) begin
         next_r.log[r.wp] = ent;
      end
      if (n_on == 2'd2) begin
         ent.evt_id = id_b;
         next_r.log[vdm_wrap(5'(r.wp) + 5'd1)] = ent;
      end
      next_r.wp   = vdm_wrap(5'(r.wp) + 5'(n_on));
      next_r.fill = ((5'(r.fill) + 5'(n_on)) > 5'(LOG_DEPTH)) ?
                    4'(LOG_DEPTH) : 4'(r.fill + 4'(n_on));

      // Address phase capture and read data
      next_r.wr_pend = addr_ok && hwrite_i;
      next_r.wr_addr = haddr_i[7:0];
      rd_idx = vdm_wrap(5'(r.wp) + 5'(LOG_DEPTH - 1) - 5'(r.log_sel));
      ent    = r.log[rd_idx];
      if (addr_ok && !hwrite_i) begin
         case (haddr_i[7:0])
            VDM_OFS_CTRL:      next_r.hrdata = {21'h0, r.group, 2'b00, r.meas_power,
                                                r.ln_mode, r.ln_allow, r.enable};
            VDM_OFS_PICKUP:    next_r.hrdata = {18'h0, r.pickup};
            VDM_OFS_DELAY:     next_r.hrdata = {13'h0, r.delay};
            VDM_OFS_EVTSEL:    next_r.hrdata = {26'h0, r.evt_sel};
            VDM_OFS_STATUS:    next_r.hrdata = {20'h0, r.fill, r.blocked, r.alarm,
                                                r.start, r.behav, r.cond};
            VDM_OFS_CNT_START: next_r.hrdata = {16'h0, r.cnt[EV_START]};
            VDM_OFS_CNT_ALARM: next_r.hrdata = {16'h0, r.cnt[EV_ALARM]};
            VDM_OFS_CNT_BLK:   next_r.hrdata = {16'h0, r.cnt[EV_BLK]};
            VDM_OFS_LOGSEL:    next_r.hrdata = {28'h0, r.log_sel};
            VDM_OFS_LOG_TLO:   next_r.hrdata = ent.stamp[31:0];
            VDM_OFS_LOG_THI:   next_r.hrdata = {6'h0, ent.evt_id, 1'b0, ent.group,
                                                4'h0, ent.stamp[47:32]};
            VDM_OFS_LOG_THDA:  next_r.hrdata = {2'b00, ent.thd[1], 2'b00, ent.thd[0]};
            VDM_OFS_LOG_THDB:  next_r.hrdata = {18'h0, ent.thd[2]};
            default:           next_r.hrdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r          <= '0;
         r.enable   <= 1'b1;
         r.ln_mode  <= BEH_ON;
         r.pickup   <= PICKUP_RST;
         r.delay    <= DELAY_RST;
         r.evt_sel  <= EVTSEL_RST;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flops, bus ready and response tied off
   assign hrdata_o      = r.hrdata;
   assign hreadyout_o   = 1'b1;
   assign hresp_o       = 1'b0;
   assign meas_power_o  = r.meas_power;
   assign start_o       = r.start;
   assign alarm_o       = r.alarm;
   assign blocked_o     = r.blocked;
   assign cond_o        = r.cond;
   assign behav_o       = r.behav;
   assign behav_valid_o = r.ln_allow;
   assign evt_valid_o   = r.evt_valid;
   assign evt_on_o      = r.evt_on;
   assign evt_time_o    = r.evt_time;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_start_on;
      !start_o ##1 start_o;
   endsequence
   sequence s_start_off;
      start_o ##1 !start_o;
   endsequence

   a_disabled_quiet:  assert property (cycle_tick_i && !r.enable |=> !start_o && !alarm_o)
      else $error("start or alarm while disabled");
   a_pickup_start:    assert property (cycle_tick_i && active && !blk_now &&
                                       ((thd_l1_i > r.pickup) || (thd_l2_i > r.pickup) ||
                                        (thd_l3_i > r.pickup)) |=> start_o)
      else $error("no start on unblocked pick-up");
   a_pickup_blocked:  assert property (cycle_tick_i && pick_now && blk_now
                                       |=> blocked_o && !start_o && !alarm_o)
      else $error("blocked pick-up not flagged");
   a_hyst_hold:       assert property (cycle_tick_i && r.picked && active &&
                                       (21'(thd_l2_i) * 21'd100 >= 21'(r.pickup) * 21'd97)
                                       |=> r.picked)
      else $error("released above reset ratio");
   a_release_both:    assert property (s_start_off |-> !alarm_o && r.tmr == '0)
      else $error("alarm outlived start");
   // Alarm only after start has run through the whole delay, when the delay is not zero
   a_alarm_timing:    assert property ($rose(alarm_o) && (r.delay != '0)
                                       |-> $past(start_o) && (r.tmr >= r.delay))
      else $error("alarm before full delay");
   a_cond_code:       assert property (alarm_o |-> cond_o == COND_ALARM && start_o)
      else $error("condition code mismatch");
   a_event_stamp:     assert property (|evt_on_o |-> evt_time_o == $past(time_ms_i))
      else $error("event stamp wrong");
   a_count_start:     assert property (s_start_on |-> r.cnt[EV_START] != '0)
      else $error("start counter not advanced");
   a_log_write:       assert property (s_start_on |-> r.wp != $past(r.wp))
      else $error("log pointer did not move");
   a_blocked_alone:   assert property (blocked_o |-> !start_o && !alarm_o)
      else $error("blocked together with start or alarm");

endmodule : vdm_monitor

// ===== vdm_front.sv
// Model of the measurement front end and blocking matrix.
// Assumes the bench sets the THD and blocking requests it wants.
`timescale 1ns/1ns
module vdm_front
   import vdm_pkg::*;
#(
   parameter int TICK_CYC = 40
)(
   // Clock and reset
   input  wire logic              sys_clk_i,
   input  wire logic              rst_i,
   // Requests from the bench
   input  wire logic [THD_W-1:0]  set_l2_i,
   input  wire logic              set_blk_i,
   // Toward the monitor
   output logic                   tick_o,
   output logic      [THD_W-1:0]  l2_o,
   output logic                   block_o,
   output logic      [TIME_W-1:0] time_o
);
   logic [7:0] div;

   // Processing tick, new figures and blocking once per cycle
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div     <= 8'h00;
         tick_o  <= 1'b0;
         l2_o    <= '0;
         block_o <= 1'b0;
         time_o  <= '0;
      end else begin
         div    <= (div == 8'(TICK_CYC - 1)) ? 8'h00 : div + 8'h01;
         tick_o <= (div == 8'(TICK_CYC - 1));
         if (div == 8'(TICK_CYC - 1)) begin
            l2_o    <= set_l2_i;
            block_o <= set_blk_i;
            time_o  <= time_o + TIME_W'(TICK_MS);
         end
      end
   end
endmodule : vdm_front

// ===== vdm_monitor_tb.sv
// Self-checking bench of the voltage distortion monitor.
// Assumes one AHB-Lite master and the front-end model beside it.
`timescale 1ns/1ns
module vdm_monitor_tb
   import vdm_pkg::*;
;
   logic              sys_clk_i, rst_i, hsel, hwrite, hready, hresp, blk;
   logic [1:0]        htrans;
   logic [31:0]       haddr, hwdata, hrdata, rd;
   logic [THD_W-1:0]  l2, s2, l3;
   logic [2:0]        ev_valid, ev_on, seen_on, seen_off;
   logic [TIME_W-1:0] ev_time;
   logic [TIME_W-1:0] tms;
   logic              tick, blk_in, power, start, alarm, blocked, bvalid;
   logic [1:0]        cond;
   logic [2:0]        behav;
   int                fail_count, check_count;

   // ---------------------------------------------------------------
   // Clock, models and design
   // ---------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   vdm_front #(.TICK_CYC(40)) front (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .set_l2_i(s2), .set_blk_i(blk_in), .tick_o(tick), .l2_o(l2),
      .block_o(blk), .time_o(tms));
   vdm_monitor dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .cycle_tick_i(tick),
      .thd_l1_i(14'h01F4), .thd_l2_i(l2), .thd_l3_i(l3),
      .block_i(blk), .time_ms_i(tms), .meas_power_o(power),
      .start_o(start), .alarm_o(alarm), .blocked_o(blocked), .cond_o(cond),
      .behav_o(behav), .behav_valid_o(bvalid), .evt_valid_o(ev_valid),
      .evt_on_o(ev_on), .evt_time_o(ev_time));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      if (fail_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Start, alarm, blocked and condition against expectation
   task automatic chk_pins(input logic [4:0] exp);
      check_count++;
      if ({start, alarm, blocked, cond} !== exp) begin
         fail_count++;
         $display("FAIL %0t outputs %b expected %b", $time,
                  {start, alarm, blocked, cond}, exp);
      end
   endtask : chk_pins

   // Bounded wait for hready at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge sys_clk_i);
      while (hready !== 1'b1) begin
         n++;
         if (n > 16) begin
            fail_count++;
            $display("FAIL %0t bus wait ran out", $time);
            finish_test();
         end
         @(posedge sys_clk_i);
      end
   endtask : wait_rdy

   // One single word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge sys_clk_i);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {24'h00_0000, a};
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask : rd_chk

   // Wait for k processing ticks, then let outputs settle
   task automatic step(input int k);
      int n;
      n = 0;
      repeat (k) begin
         @(posedge sys_clk_i);
         while (tick !== 1'b1) begin
            n++;
            if (n > 400) begin
               fail_count++;
               $display("FAIL %0t tick wait ran out", $time);
               finish_test();
            end
            @(posedge sys_clk_i);
         end
      end
      #1;
   endtask : step

   // New front-end figures, acted on within two ticks, return after the second
   task automatic apply(input logic [THD_W-1:0] v, input logic b);
      @(posedge sys_clk_i);
      s2     <= v;
      blk_in <= b;
      step(2);
   endtask : apply

   // Event pulses gathered between edges, stamp checked on ON edges
   always @(negedge sys_clk_i) begin
      if (!rst_i) begin
         seen_on  <= seen_on | (ev_valid & ev_on);
         seen_off <= seen_off | (ev_valid & ~ev_on);
         if (|ev_on) begin
            chk(ev_time[31:0], tms[31:0]);
         end
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {hsel, hwrite, blk_in, htrans} = '0;
      {haddr, hwdata, s2, l3, seen_on, seen_off} = '0;
      fail_count = 0;
      check_count = 0;
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd_chk(VDM_OFS_CTRL, 32'h0000_0001);
      rd_chk(VDM_OFS_PICKUP, 32'h0000_03E8);
      rd_chk(VDM_OFS_DELAY, 32'h0000_07D0);
      rd_chk(VDM_OFS_EVTSEL, 32'h0000_003F);
      rd_chk(8'h3C, 32'h0000_0000);
      bus(1'b1, VDM_OFS_DELAY, 32'h0000_0003);
      apply(14'h03E8, 1'b0);
      chk_pins(5'b00000);
      apply(14'h03E9, 1'b0);
      chk_pins(5'b10001);
      step(1);
      chk_pins(5'b10001);
      step(1);
      chk_pins(5'b11010);
      rd_chk(VDM_OFS_STATUS, 32'h0000_0262);
      rd_chk(VDM_OFS_LOG_THI, 32'h0200_0000);
      rd_chk(VDM_OFS_LOG_THDA, 32'h03E9_01F4);
      bus(1'b1, VDM_OFS_LOGSEL, 32'h0000_0001);
      rd_chk(VDM_OFS_LOG_THI, 32'h0100_0000);
      apply(14'h03CA, 1'b0);
      chk_pins(5'b11010);
      apply(14'h03C9, 1'b0);
      chk_pins(5'b00000);
      rd_chk(VDM_OFS_CNT_START, 32'h0000_0001);
      rd_chk(VDM_OFS_CNT_ALARM, 32'h0000_0001);
      bus(1'b1, VDM_OFS_CNTCLR, 32'h0000_0007);
      rd_chk(VDM_OFS_CNT_START, 32'h0000_0000);
      bus(1'b1, VDM_OFS_CTRL, 32'h0000_0000);
      apply(14'h07D0, 1'b0);
      chk_pins(5'b00000);
      bus(1'b1, VDM_OFS_CTRL, 32'h0000_0013);
      step(2);
      chk_pins(5'b00000);
      chk({28'h000_0000, bvalid, behav}, 32'h0000_000C);
      bus(1'b1, VDM_OFS_DELAY, 32'h0000_0032);
      bus(1'b1, VDM_OFS_CTRL, 32'h0000_0021);
      step(2);
      chk_pins(5'b10001);
      chk({30'h0000_0000, bvalid, power}, 32'h0000_0001);
      apply(14'h07D0, 1'b1);
      chk_pins(5'b00111);
      apply(14'h0000, 1'b0);
      apply(14'h07D0, 1'b1);
      chk_pins(5'b00111);
      apply(14'h07D0, 1'b0);
      chk_pins(5'b10001);
      apply(14'h0000, 1'b0);
      chk_pins(5'b00000);
      @(posedge sys_clk_i);
      l3 <= 14'h03E9;
      step(2);
      chk_pins(5'b10001);
      chk({26'h000_0000, seen_off, seen_on}, 32'h0000_003F);
      finish_test();
   end
endmodule : vdm_monitor_tb
